// *** logic/rnv_core.sv ***
// Behaviour
// - Multi load reads words, checksumming them.
// - Multi load of two or more targets only registers 10..199.
// - Checksum mismatch sets status bits 14, 12.
// - NV address zero uses register 10.
// - Start register: zero indirect, negative suppresses.
// - Suppressed load reports zero or negative flag.
// - Multi load code 197: count, start, address.
// - Single load code 199 acts as count one.
// - Single load writes writable registers only.
// - One thread at a time owns memory.
// - Store writes array then its checksum.
// - Multi store of two or more sources only registers 10..199.
// - Each register stored as two halves.
// - Protected store sets status bits 12, 14.
// - Suppressed store reports zero or negative flag.
// - Multi store code 196: count, start, address.
//
// Local design decisions: the placing of the registers and the address-and-strobe port.
module rnv_core (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       resetn,
  // Commands from the two program threads
  input  wire logic               [1:0]   cmd_valid,
  input  wire rnv_pkg::rnv_cmd_s  [1:0]   cmd_req,
  input  wire logic               [1:0][31:0] acc,
  output logic                    [1:0]   cmd_ack,
  output rnv_pkg::rnv_ist_s       [1:0]   ist,
  output logic                            cmd_err,
  // Data register file
  output logic                    [7:0]   reg_addr,
  output logic                    [31:0]  reg_wdata,
  output logic                            reg_we,
  output logic                            reg_re,
  input  wire logic               [31:0]  reg_rdata,
  input  wire logic               [255:0] reg_writable,
  // Non-volatile memory, 16-bit words
  output logic                    [15:0]  nv_addr,
  output logic                    [15:0]  nv_wdata,
  output logic                            nv_we,
  output logic                            nv_re,
  input  wire logic               [15:0]  nv_rdata,
  // Register bus
  input  wire logic               [3:0]   bus_addr,
  input  wire logic               [31:0]  bus_wdata,
  input  wire logic                       bus_we,
  input  wire logic                       bus_re,
  output logic                    [31:0]  bus_rdata
);

  rnv_pkg::rnv_state_e state_reg, state_next;
  rnv_pkg::rnv_cmd_s   cmd_reg, cmd_next;
  rnv_pkg::rnv_ist_s   [1:0] ist_reg, ist_next;
  logic        thr_reg, thr_next;
  logic [15:0] base_reg, base_next;
  logic [7:0]  regi_reg, regi_next;
  logic [4:0]  cnt_reg, cnt_next;
  logic [4:0]  widx_reg, widx_next;
  logic [31:0] hold_reg, hold_next;
  logic        err_reg, err_next;
  logic        sup_reg, sup_next;
  logic        is_load_reg, is_load_next;
  logic [7:0]  reg_addr_reg, reg_addr_next;
  logic [31:0] reg_wdata_reg, reg_wdata_next;
  logic        reg_we_reg, reg_we_next, reg_re_reg, reg_re_next;
  logic [15:0] nv_addr_reg, nv_addr_next, nv_wdata_reg, nv_wdata_next;
  logic        nv_we_reg, nv_we_next, nv_re_reg, nv_re_next;
  logic        cmd_err_reg, cmd_err_next;
  logic        set_fail, set_cerr;
  logic        sum_clr, sum_add;
  logic [15:0] sum_val, sum_q;
  logic [1:0]  grant;
  // Command check terms.
  logic [15:0] start_mag;
  logic [7:0]  start_eff;
  logic [4:0]  cnt_eff;
  logic [8:0]  last_reg_num;
  logic        op_load, op_store, bad_op, bad_cnt, bad_range, bad_wr, bad_prot;
  // Bus registers.
  logic [15:0] pst_reg, pst_next, prot_reg, prot_next;
  logic [31:0] bus_rdata_reg, bus_rdata_next;

  rnv_arbiter u_arb (
    .clk           (clk),
    .resetn        (resetn),
    .req           (cmd_valid),
    .release_grant (state_reg == rnv_pkg::S_FIN),
    .grant         (grant)
  );

  rnv_checksum u_sum (
    .clk     (clk),
    .resetn  (resetn),
    .clear   (sum_clr),
    .add_en  (sum_add),
    .add_val (sum_val),
    .sum     (sum_q)
  );

  always_comb begin
    op_load   = cmd_reg.opcode == rnv_pkg::OP_LOAD_MULTI || cmd_reg.opcode == rnv_pkg::OP_LOAD_SINGLE;
    op_store  = cmd_reg.opcode == rnv_pkg::OP_STORE_MULTI;
    bad_op    = !op_load && !op_store;
    start_mag = cmd_reg.start[15] ? 16'(-cmd_reg.start) : cmd_reg.start;
    start_eff = (start_mag == 16'h0000) ? acc[thr_reg][7:0] : start_mag[7:0];
    if (cmd_reg.opcode == rnv_pkg::OP_LOAD_SINGLE) begin
      cnt_eff = 5'h01;
      bad_cnt = 1'b0;
    end else begin
      cnt_eff = cmd_reg.count[4:0];
      bad_cnt = cmd_reg.count < 16'sh0001 || cmd_reg.count > $signed(rnv_pkg::MAX_COUNT);
    end
    last_reg_num = 9'(start_eff) + 9'(cnt_eff) - 9'h001;
    bad_range = (start_mag > rnv_pkg::MAX_REG) || (cnt_eff > 5'h01 && (9'(start_eff) < rnv_pkg::MULTI_REG_LO
                || last_reg_num > rnv_pkg::MULTI_REG_HI));
    bad_wr    = op_load && cnt_eff == 5'h01 && !reg_writable[start_eff];
    bad_prot  = op_store && base_reg < prot_reg;
  end

  always_comb begin
    state_next     = state_reg;
    cmd_next       = cmd_reg;
    ist_next       = ist_reg;
    thr_next       = thr_reg;
    base_next      = base_reg;
    regi_next      = regi_reg;
    cnt_next       = cnt_reg;
    widx_next      = widx_reg;
    hold_next      = hold_reg;
    err_next       = err_reg;
    sup_next       = sup_reg;
    is_load_next   = is_load_reg;
    reg_addr_next  = reg_addr_reg;
    reg_wdata_next = reg_wdata_reg;
    reg_we_next    = 1'b0;
    reg_re_next    = 1'b0;
    nv_addr_next   = nv_addr_reg;
    nv_wdata_next  = nv_wdata_reg;
    nv_we_next     = 1'b0;
    nv_re_next     = 1'b0;
    cmd_err_next   = 1'b0;
    set_fail       = 1'b0;
    set_cerr       = 1'b0;
    sum_clr        = 1'b0;
    sum_add        = 1'b0;
    sum_val        = 16'h0000;
    unique case (state_reg)
      rnv_pkg::S_IDLE: begin
        if (grant[0] && cmd_valid[0]) begin
          thr_next   = 1'b0;
          cmd_next   = cmd_req[0];
          state_next = rnv_pkg::S_CHECK;
        end else if (grant[1] && cmd_valid[1]) begin
          thr_next   = 1'b1;
          cmd_next   = cmd_req[1];
          state_next = rnv_pkg::S_CHECK;
        end
        base_next = (cmd_next.nv_addr == 16'h0000) ? acc[thr_next][15:0] : cmd_next.nv_addr;
      end
      rnv_pkg::S_CHECK: begin
        sum_clr      = 1'b1;
        sup_next     = cmd_reg.start[15];
        is_load_next = op_load;
        regi_next    = start_eff;
        cnt_next     = cnt_eff;
        widx_next    = 5'h00;
        err_next     = bad_op || bad_cnt || bad_range || bad_wr || bad_prot;
        set_fail     = bad_prot && !cmd_reg.start[15];
        if (bad_op || bad_cnt || bad_range || bad_wr || bad_prot) begin
          state_next = rnv_pkg::S_FIN;
        end else if (op_load) begin
          state_next = rnv_pkg::S_LD_REQ;
        end else begin
          state_next = rnv_pkg::S_ST_RREQ;
        end
      end
      rnv_pkg::S_LD_REQ: begin
        nv_re_next   = 1'b1;
        nv_addr_next = base_reg + 16'(widx_reg);
        state_next   = rnv_pkg::S_LD_WAIT;
      end
      rnv_pkg::S_LD_WAIT: begin
        state_next = rnv_pkg::S_LD_CAP;
      end
      rnv_pkg::S_LD_CAP: begin
        state_next = rnv_pkg::S_LD_REQ;
        widx_next  = widx_reg + 5'h01;
        if (widx_reg == {cnt_reg[3:0], 1'b0}) begin
          // Last word is the stored checksum.
          if (nv_rdata != sum_q) begin
            err_next = 1'b1;
            set_fail = 1'b1;
          end
          state_next = rnv_pkg::S_FIN;
        end else begin
          sum_add = 1'b1;
          sum_val = nv_rdata;
          if (!widx_reg[0]) begin
            hold_next[15:0] = nv_rdata;
          end else begin
            reg_we_next    = 1'b1;
            reg_addr_next  = regi_reg;
            reg_wdata_next = {nv_rdata, hold_reg[15:0]};
            regi_next      = regi_reg + 8'h01;
          end
        end
      end
      rnv_pkg::S_ST_RREQ: begin
        reg_re_next   = 1'b1;
        reg_addr_next = regi_reg;
        state_next    = rnv_pkg::S_ST_WAIT;
      end
      rnv_pkg::S_ST_WAIT: begin
        state_next = rnv_pkg::S_ST_LO;
      end
      rnv_pkg::S_ST_LO: begin
        hold_next     = reg_rdata;
        nv_we_next    = 1'b1;
        nv_addr_next  = base_reg + 16'(widx_reg);
        nv_wdata_next = reg_rdata[15:0];
        sum_add       = 1'b1;
        sum_val       = reg_rdata[15:0];
        widx_next     = widx_reg + 5'h01;
        state_next    = rnv_pkg::S_ST_HI;
      end
      rnv_pkg::S_ST_HI: begin
        // The checksum word follows the array once every half is written.
        nv_we_next   = 1'b1;
        nv_addr_next = base_reg + 16'(widx_reg);
        widx_next    = widx_reg + 5'h01;
        if (widx_reg == {cnt_reg[3:0], 1'b0}) begin
          nv_wdata_next = sum_q;
          state_next    = rnv_pkg::S_FIN;
        end else begin
          nv_wdata_next = hold_reg[31:16];
          sum_add       = 1'b1;
          sum_val       = hold_reg[31:16];
          regi_next     = regi_reg + 8'h01;
          state_next    = (widx_reg + 5'h01 == {cnt_reg[3:0], 1'b0}) ? rnv_pkg::S_ST_HI : rnv_pkg::S_ST_RREQ;
        end
      end
      rnv_pkg::S_FIN: begin
        ist_next[thr_reg].zero = !err_reg;
        ist_next[thr_reg].neg  = err_reg;
        cmd_err_next           = err_reg && !sup_reg;
        set_cerr               = err_reg && !sup_reg;
        state_next             = rnv_pkg::S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_reg     <= rnv_pkg::S_IDLE;
      cmd_reg       <= '0;
      ist_reg       <= '0;
      thr_reg       <= 1'b0;
      base_reg      <= 16'h0000;
      regi_reg      <= 8'h00;
      cnt_reg       <= 5'h00;
      widx_reg      <= 5'h00;
      hold_reg      <= 32'h00000000;
      err_reg       <= 1'b0;
      sup_reg       <= 1'b0;
      is_load_reg   <= 1'b0;
      reg_addr_reg  <= 8'h00;
      reg_wdata_reg <= 32'h00000000;
      reg_we_reg    <= 1'b0;
      reg_re_reg    <= 1'b0;
      nv_addr_reg   <= 16'h0000;
      nv_wdata_reg  <= 16'h0000;
      nv_we_reg     <= 1'b0;
      nv_re_reg     <= 1'b0;
      cmd_err_reg   <= 1'b0;
    end else begin
      state_reg     <= state_next;
      cmd_reg       <= cmd_next;
      ist_reg       <= ist_next;
      thr_reg       <= thr_next;
      base_reg      <= base_next;
      regi_reg      <= regi_next;
      cnt_reg       <= cnt_next;
      widx_reg      <= widx_next;
      hold_reg      <= hold_next;
      err_reg       <= err_next;
      sup_reg       <= sup_next;
      is_load_reg   <= is_load_next;
      reg_addr_reg  <= reg_addr_next;
      reg_wdata_reg <= reg_wdata_next;
      reg_we_reg    <= reg_we_next;
      reg_re_reg    <= reg_re_next;
      nv_addr_reg   <= nv_addr_next;
      nv_wdata_reg  <= nv_wdata_next;
      nv_we_reg     <= nv_we_next;
      nv_re_reg     <= nv_re_next;
      cmd_err_reg   <= cmd_err_next;
    end
  end

  // Software clears status bits by writing ones; a hardware set in the same cycle wins.
  always_comb begin
    pst_next       = pst_reg;
    prot_next      = prot_reg;
    bus_rdata_next = 32'h00000000;
    if (bus_we && bus_addr == rnv_pkg::ADDR_PST) begin
      pst_next = pst_reg & ~bus_wdata[15:0];
    end
    if (bus_we && bus_addr == rnv_pkg::ADDR_PROTECT) begin
      prot_next = bus_wdata[15:0];
    end
    if (set_fail) begin
      pst_next[rnv_pkg::PST_LOAD_FAIL_BIT] = 1'b1;
      pst_next[rnv_pkg::PST_CMD_ERR_BIT]   = 1'b1;
    end
    if (set_cerr) begin
      pst_next[rnv_pkg::PST_CMD_ERR_BIT] = 1'b1;
    end
    if (bus_re) begin
      unique case (bus_addr)
        rnv_pkg::ADDR_PST:     bus_rdata_next = {16'h0000, pst_reg};
        rnv_pkg::ADDR_STATUS:  bus_rdata_next = {20'h00000, ist_reg, grant, thr_reg, is_load_reg,
                                                 state_reg != rnv_pkg::S_IDLE, 1'b0, err_reg, sup_reg};
        rnv_pkg::ADDR_PROTECT: bus_rdata_next = {16'h0000, prot_reg};
        default:               bus_rdata_next = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      pst_reg       <= 16'h0000;
      prot_reg      <= rnv_pkg::PROTECT_RST;
      bus_rdata_reg <= 32'h00000000;
    end else begin
      pst_reg       <= pst_next;
      prot_reg      <= prot_next;
      bus_rdata_reg <= bus_rdata_next;
    end
  end

  assign cmd_ack   = (state_reg == rnv_pkg::S_FIN) ? (thr_reg ? 2'h2 : 2'h1) : 2'h0;
  assign ist       = ist_reg;
  assign cmd_err   = cmd_err_reg;
  assign reg_addr  = reg_addr_reg;
  assign reg_wdata = reg_wdata_reg;
  assign reg_we    = reg_we_reg;
  assign reg_re    = reg_re_reg;
  assign nv_addr   = nv_addr_reg;
  assign nv_wdata  = nv_wdata_reg;
  assign nv_we     = nv_we_reg;
  assign nv_re     = nv_re_reg;
  assign bus_rdata = bus_rdata_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  one_owner_a: assert property (cmd_ack != 2'h3 && grant != 2'h3) else $error("two threads own memory");
  grant_held_a: assert property (state_reg != rnv_pkg::S_IDLE |-> grant == $past(grant))
    else $error("grant moved during access");
  load_fail_a: assert property (state_reg == rnv_pkg::S_LD_CAP && widx_reg == {cnt_reg[3:0], 1'b0} && nv_rdata != sum_q
    |=> pst_reg[14] && pst_reg[12] && cmd_ack != 2'h0) else $error("checksum mismatch not flagged");
  prot_store_a: assert property (state_reg == rnv_pkg::S_CHECK && bad_prot && !cmd_reg.start[15]
    |=> pst_reg[14] && pst_reg[12] && !nv_we)
    else $error("protected store not refused");
  two_halves_a: assert property (state_reg == rnv_pkg::S_ST_LO |=> nv_we_reg ##1 nv_we_reg && nv_addr_reg == $past(nv_addr_reg) + 16'h0001)
    else $error("register not stored as two halves");
  multi_range_a: assert property (reg_we_reg && cnt_reg > 5'h01 |-> reg_addr_reg >= 8'h0A && reg_addr_reg <= 8'hC7)
    else $error("multi load outside range");
  single_wr_a: assert property (reg_we_reg && cnt_reg == 5'h01 |-> reg_writable[reg_addr_reg])
    else $error("single load hit read-only register");
  indirect_a: assert property (state_reg == rnv_pkg::S_CHECK && cmd_reg.nv_addr == 16'h0000 |-> base_reg == acc[thr_reg][15:0])
    else $error("indirect address not taken");
  ist_report_a: assert property (state_reg == rnv_pkg::S_FIN |=> ist_reg[$past(thr_reg)].neg == $past(err_reg)
    && ist_reg[$past(thr_reg)].zero != $past(err_reg)) else $error("status flags wrong");
  ack_pulse_a: assert property (cmd_ack != 2'h0 |=> cmd_ack == 2'h0) else $error("ack longer than one cycle");

  load_done_c: cover property (state_reg == rnv_pkg::S_FIN && is_load_reg && !err_reg);
  store_done_c: cover property (state_reg == rnv_pkg::S_FIN && !is_load_reg && !err_reg);
  both_wait_c: cover property (cmd_valid == 2'h3 && state_reg == rnv_pkg::S_LD_CAP);

endmodule

// *** logic/rnv_pkg.sv ***
package rnv_pkg;

  // Command codes.
  localparam logic [7:0] OP_STORE_MULTI = 8'hC4;
  localparam logic [7:0] OP_LOAD_MULTI  = 8'hC5;
  localparam logic [7:0] OP_LOAD_SINGLE = 8'hC7;

  // Register numbers and limits.
  localparam logic [7:0]  ACC_REG      = 8'h0A;
  localparam logic [8:0]  MULTI_REG_LO = 9'h00A;
  localparam logic [8:0]  MULTI_REG_HI = 9'h0C7;
  localparam logic [15:0] MAX_COUNT    = 16'h000A;
  localparam logic [15:0] MAX_REG      = 16'h00FF;

  // Polling status word bit positions.
  localparam int PST_CMD_ERR_BIT   = 12;
  localparam int PST_LOAD_FAIL_BIT = 14;

  // Register bus offsets and reset values.
  localparam logic [3:0]  ADDR_PST     = 4'h0;
  localparam logic [3:0]  ADDR_STATUS  = 4'h4;
  localparam logic [3:0]  ADDR_PROTECT = 4'h8;
  localparam logic [15:0] PROTECT_RST  = 16'h0000;

  typedef struct packed {
    logic [7:0]         opcode;
    logic signed [15:0] count;
    logic signed [15:0] start;
    logic [15:0]        nv_addr;
  } rnv_cmd_s;

  typedef struct packed {
    logic zero;
    logic neg;
  } rnv_ist_s;

  typedef enum logic [9:0] {
    S_IDLE    = 10'h001,
    S_CHECK   = 10'h002,
    S_LD_REQ  = 10'h004,
    S_LD_WAIT = 10'h008,
    S_LD_CAP  = 10'h010,
    S_ST_RREQ = 10'h020,
    S_ST_WAIT = 10'h040,
    S_ST_LO   = 10'h080,
    S_ST_HI   = 10'h100,
    S_FIN     = 10'h200
  } rnv_state_e;

endpackage

// *** logic/rnv_arbiter.sv ***
// Grants the non-volatile memory to one thread and holds it until release.
module rnv_arbiter (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // Requests and grant
  input  wire logic [1:0] req,
  input  wire logic       release_grant,
  output logic      [1:0] grant
);

  logic [1:0] grant_reg;
  logic [1:0] grant_next;
  logic       last_reg;
  logic       last_next;

  always_comb begin
    grant_next = grant_reg;
    last_next  = last_reg;
    if (release_grant) begin
      grant_next = 2'h0;
    end else if (grant_reg == 2'h0 && req != 2'h0) begin
      // Alternate when both threads wait, so neither starves.
      if (req == 2'h3) begin
        grant_next = last_reg ? 2'h1 : 2'h2;
      end else begin
        grant_next = req;
      end
      last_next = grant_next[1];
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      grant_reg <= 2'h0;
      last_reg  <= 1'b1;
    end else begin
      grant_reg <= grant_next;
      last_reg  <= last_next;
    end
  end

  assign grant = grant_reg;

endmodule

// *** logic/rnv_checksum.sv ***
// Running 16-bit additive checksum over the words of one array.
module rnv_checksum (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // Control and data
  input  wire logic        clear,
  input  wire logic        add_en,
  input  wire logic [15:0] add_val,
  output logic      [15:0] sum
);

  logic [15:0] sum_reg;
  logic [15:0] sum_next;

  always_comb begin
    sum_next = sum_reg;
    if (clear) begin
      sum_next = 16'h0000;
    end else if (add_en) begin
      sum_next = sum_reg + add_val;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      sum_reg <= 16'h0000;
    end else begin
      sum_reg <= sum_next;
    end
  end

  assign sum = sum_reg;

endmodule

// *** test/rnv_mem_model.sv ***
// Register file and non-volatile word memory that sit behind the core.
module rnv_mem_model (
  // Clock
  input  wire logic        clk,
  // Register file port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_we,
  input  wire logic        reg_re,
  output logic      [31:0] reg_rdata,
  // Non-volatile word port
  input  wire logic [15:0] nv_addr,
  input  wire logic [15:0] nv_wdata,
  input  wire logic        nv_we,
  input  wire logic        nv_re,
  output logic      [15:0] nv_rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [31:0] regs [0:255];
  logic [15:0] nv   [0:1023];

  // Read data stands only in the cycle after the strobe; otherwise it toggles so stale data never matches.
  always @(posedge clk) begin
    if (reg_we) begin
      regs[reg_addr] <= reg_wdata;
    end
    if (nv_we) begin
      nv[nv_addr[9:0]] <= nv_wdata;
    end
    reg_rdata <= reg_re ? regs[reg_addr] : ~reg_rdata;
    nv_rdata  <= nv_re ? nv[nv_addr[9:0]] : ~nv_rdata;
  end
endmodule

// *** test/tb_top.sv ***
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    rnv_pkg::rnv_cmd_s cmd;
    logic              err;
    logic [31:0]       pst;
    rnv_pkg::rnv_ist_s ist;
  } rnv_row_s;

  localparam logic [7:0]  ST  = rnv_pkg::OP_STORE_MULTI;
  localparam logic [7:0]  LM  = rnv_pkg::OP_LOAD_MULTI;
  localparam logic [7:0]  LS  = rnv_pkg::OP_LOAD_SINGLE;
  localparam logic [31:0] PE  = 32'h1 << rnv_pkg::PST_CMD_ERR_BIT;
  localparam logic [31:0] PB  = PE | (32'h1 << rnv_pkg::PST_LOAD_FAIL_BIT);
  localparam logic [1:0]  OK  = 2'b10;
  localparam logic [1:0]  BAD = 2'b01;
  localparam int          TMO = 6000;

  logic                    clk;
  logic                    resetn;
  logic [1:0]              cmd_valid;
  rnv_pkg::rnv_cmd_s [1:0] cmd_req;
  logic [1:0][31:0]        acc;
  logic [1:0]              cmd_ack;
  rnv_pkg::rnv_ist_s [1:0] ist;
  logic                    cmd_err;
  logic [7:0]              reg_addr;
  logic [31:0]             reg_wdata;
  logic                    reg_we;
  logic                    reg_re;
  logic [31:0]             reg_rdata;
  logic [255:0]            reg_writable;
  logic [15:0]             nv_addr;
  logic [15:0]             nv_wdata;
  logic                    nv_we;
  logic                    nv_re;
  logic [15:0]             nv_rdata;
  logic [3:0]              bus_addr;
  logic [31:0]             bus_wdata;
  logic                    bus_we;
  logic                    bus_re;
  logic [31:0]             bus_rdata;
  int                      error_cnt = 0;
  int                      total_checks = 0;
  int                      cyc_cnt = 0;
  rnv_row_s                rows [0:12];
  logic [31:0]             v;
  logic [31:0]             p;
  logic                    e0;
  logic                    e1;
  rnv_pkg::rnv_ist_s       f0;
  rnv_pkg::rnv_ist_s       f1;

  rnv_core u_dut (
    .clk(clk), .resetn(resetn), .cmd_valid(cmd_valid), .cmd_req(cmd_req), .acc(acc),
    .cmd_ack(cmd_ack), .ist(ist), .cmd_err(cmd_err), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .reg_writable(reg_writable),
    .nv_addr(nv_addr), .nv_wdata(nv_wdata), .nv_we(nv_we), .nv_re(nv_re), .nv_rdata(nv_rdata),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_we(bus_we), .bus_re(bus_re), .bus_rdata(bus_rdata)
  );

  rnv_mem_model u_mem (
    .clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
    .reg_rdata(reg_rdata), .nv_addr(nv_addr), .nv_wdata(nv_wdata), .nv_we(nv_we), .nv_re(nv_re),
    .nv_rdata(nv_rdata)
  );

  function automatic logic [31:0] pat(input int i);
    return 32'h1357_0000 + 32'(i) * 32'h0001_0203;
  endfunction

  // Sum of every half word of registers base .. base+n-1.
  function automatic logic [15:0] csum(input int base, input int n);
    logic [31:0] w;
    logic [15:0] s;
    s = 16'h0000;
    for (int k = 0; k < n; k++) begin
      w = pat(base + k);
      s = s + w[15:0] + w[31:16];
    end
    return s;
  endfunction

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    bus_we    <= 1'b1;
    bus_addr  <= a;
    bus_wdata <= d;
    @(posedge clk);
    bus_we    <= 1'b0;
  endtask

  task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    bus_re   <= 1'b1;
    bus_addr <= a;
    @(posedge clk);
    bus_re   <= 1'b0;
    #1;
    d = bus_rdata;
  endtask

  // Reads the polling status word, compares it and clears it again.
  task automatic chk_pst(input logic [31:0] exp);
    logic [31:0] d;
    bus_rd(rnv_pkg::ADDR_PST, d);
    chk(d, exp);
    bus_wr(rnv_pkg::ADDR_PST, 32'hFFFF_FFFF);
  endtask

  task automatic run_cmd(input int t, input rnv_pkg::rnv_cmd_s c, output logic err,
                         output rnv_pkg::rnv_ist_s f);
    int n;
    @(posedge clk);
    cmd_valid[t] <= 1'b1;
    cmd_req[t]   <= c;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (cmd_ack[t] !== 1'b1 && n < 400);
    chk({31'h0, cmd_ack[t]}, 32'h1);
    @(posedge clk);
    cmd_valid[t] <= 1'b0;
    #1;
    err = cmd_err;
    f   = ist[t];
  endtask

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == TMO) begin
      error_cnt++;
      give_verdict();
    end
  end

  initial begin
    resetn = 1'b0;
    cmd_valid = 2'b00;
    cmd_req = '0;
    acc[0] = 32'h0000_0064;
    acc[1] = 32'h0000_00C8;
    bus_addr = 4'h0;
    bus_wdata = 32'h0;
    bus_we = 1'b0;
    bus_re = 1'b0;
    reg_writable = {256{1'b1}} ^ (256'h1 << 250);
    for (int i = 0; i < 256; i++) u_mem.regs[i] = pat(i);
    for (int j = 0; j < 1024; j++) u_mem.nv[j] = 16'hC000 | 16'(j);
    rows = '{
      '{'{ST, 16'sh0003, 16'sh0014, 16'h0064}, 1'b0, 32'h0, OK},
      '{'{LM, 16'sh0003, 16'sh0028, 16'h0064}, 1'b0, 32'h0, OK},
      '{'{ST, 16'sh0001, 16'sh003C, 16'h00C8}, 1'b0, 32'h0, OK},
      '{'{LS, 16'sh0001, 16'sh00E6, 16'h00C8}, 1'b0, 32'h0, OK},
      '{'{LM, 16'sh0003, 16'sh0000, 16'h0000}, 1'b0, 32'h0, OK},
      '{'{LM, 16'sh0002, 16'sh00C7, 16'h0064}, 1'b1, PE, BAD},
      '{'{ST, 16'sh0002, 16'sh0005, 16'h01F4}, 1'b1, PE, BAD},
      '{'{ST, 16'sh000B, 16'sh0014, 16'h01F4}, 1'b1, PE, BAD},
      '{'{LS, 16'sh0001, 16'sh00FA, 16'h00C8}, 1'b1, PE, BAD},
      '{'{LM, 16'sh0002, -16'sh00C7, 16'h0064}, 1'b0, 32'h0, BAD},
      '{'{ST, 16'sh0001, -16'sh0014, 16'h012C}, 1'b0, 32'h0, OK},
      '{'{ST, 16'sh0001, 16'sh0014, 16'h000A}, 1'b1, PB, BAD},
      '{'{ST, 16'sh0001, -16'sh0014, 16'h000A}, 1'b0, 32'h0, BAD}
    };
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    bus_rd(rnv_pkg::ADDR_PROTECT, v);
    chk(v, {16'h0000, rnv_pkg::PROTECT_RST});
    chk_pst(32'h0);
    // Addresses below 0x50 become protected for the stores that follow.
    bus_wr(rnv_pkg::ADDR_PROTECT, 32'h0000_0050);
    for (int i = 0; i <= 12; i++) begin
      run_cmd(0, rows[i].cmd, e0, f0);
      chk({31'h0, e0}, {31'h0, rows[i].err});
      chk({30'h0, f0}, {30'h0, rows[i].ist});
      chk_pst(rows[i].pst);
    end
    for (int k = 0; k < 3; k++) begin
      p = pat(20 + k);
      chk({16'h0, u_mem.nv[100 + 2 * k]}, {16'h0, p[15:0]});
      chk({16'h0, u_mem.nv[101 + 2 * k]}, {16'h0, p[31:16]});
      chk(u_mem.regs[40 + k], p);
      chk(u_mem.regs[100 + k], p);
    end
    chk({16'h0, u_mem.nv[106]}, {16'h0, csum(20, 3)});
    chk(u_mem.regs[230], pat(60));
    chk({16'h0, u_mem.nv[302]}, {16'h0, csum(20, 1)});
    chk({16'h0, u_mem.nv[10]}, 32'h0000_C00A);
    chk({16'h0, u_mem.nv[500]}, 32'h0000_C1F4);
    chk(u_mem.regs[250], pat(250));
    chk(u_mem.regs[199], pat(199));
    // A corrupted checksum word must be reported as a failed load.
    u_mem.nv[106] = u_mem.nv[106] ^ 16'h0001;
    run_cmd(0, '{LM, 16'sh0003, 16'sh0028, 16'h0064}, e0, f0);
    chk({30'h0, f0}, {30'h0, BAD});
    chk_pst(PB);
    fork
      run_cmd(0, '{ST, 16'sh0003, 16'sh0014, 16'h0190}, e0, f0);
      run_cmd(1, '{LS, 16'sh0001, 16'sh0046, 16'h00C8}, e1, f1);
    join
    chk({28'h0, f1, f0}, {28'h0, OK, OK});
    chk(u_mem.regs[70], pat(60));
    chk({16'h0, u_mem.nv[406]}, {16'h0, csum(20, 3)});
    bus_wr(4'hC, 32'hFFFF_FFFF);
    bus_rd(4'hC, v);
    chk(v, 32'h0);
    bus_rd(rnv_pkg::ADDR_PROTECT, v);
    chk(v, 32'h0000_0050);
    give_verdict();
  end
endmodule
